// ### flash_ctrl_consts.svh
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH

`define PAGE_BYTES 8'd128
`define PAGE_CNT_W 7
`define ERASED_BYTE 8'hff
`define PAGE_ALIGN_MASK 8'h7f
`define VERIFY_ALIGN_MASK 16'h0003
`define STS_W 3
`define STABLE_TIME_NS 20000
`define CLK_PERIOD_NS 8
`define STABLE_CYCLES ((`STABLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAIT_CNT_W 16
`define MODE_RST 4'h0

`endif

// ### flash_ctrl_pkg.sv
package flash_ctrl_pkg;
	typedef struct packed {
		logic prog;
		logic prog_verify;
		logic erase;
		logic erase_verify;
	} mode_s;

	typedef struct packed {
		logic we;
		logic re;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cpu_acc_s;

	typedef enum logic [1:0] {
		PWR_NORMAL = 2'b00,
		PWR_DOWN = 2'b01,
		PWR_STANDBY = 2'b10,
		PWR_WAKE = 2'b11
	} pwr_e;
endpackage

// ### flash_pwr_ctrl.sv
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_pwr_ctrl
	import flash_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic subactive,
	input wire logic standby_req,
	input wire logic flash_powerdown_enable,
	input wire logic [`STS_W-1:0] standby_wait_select,
	output pwr_e state,
	output logic ready
);
	pwr_e state_ff, nxt_state;
	logic [`WAIT_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [`WAIT_CNT_W-1:0] wait_len;

	// wait grows with select, never under the stabilisation floor
	assign wait_len = `WAIT_CNT_W'(`STABLE_CYCLES) + `WAIT_CNT_W'({standby_wait_select, 10'h000});

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			PWR_NORMAL: begin
				if (standby_req) begin
					nxt_state = PWR_STANDBY;
				end else if (subactive && flash_powerdown_enable) begin
					nxt_state = PWR_DOWN;
				end
			end
			PWR_DOWN, PWR_STANDBY: begin
				if (standby_req) begin
					nxt_state = PWR_STANDBY;
				end else if (!(subactive && flash_powerdown_enable)) begin
					nxt_state = PWR_WAKE;
					nxt_cnt = wait_len;
				end
			end
			PWR_WAKE: begin
				if (cnt_ff == '0) begin
					nxt_state = PWR_NORMAL;
				end else begin
					nxt_cnt = cnt_ff - 1'b1;
				end
			end
			default: nxt_state = PWR_NORMAL;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= PWR_NORMAL;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	assign state = state_ff;
	assign ready = (state_ff == PWR_NORMAL);
endmodule // flash_pwr_ctrl

// ### flash_program_erase_control.sv
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_program_erase_control
	import flash_ctrl_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic POR,
	input wire cpu_acc_s CPU,
	input wire mode_s MODE_SET,
	input wire logic PROG_PULSE,
	input wire logic ERASE_PULSE,
	input wire logic [7:0] ERASE_BLOCK_SELECT,
	input wire logic ERROR_DETECT,
	input wire logic SUBACTIVE,
	input wire logic STANDBY_REQ,
	input wire logic FLASH_POWERDOWN_ENABLE,
	input wire logic [`STS_W-1:0] STANDBY_WAIT_SELECT,
	output mode_s MODE,
	output logic [7:0] BLOCK_SEL,
	output logic PROGRAMMING,
	output logic ERASING,
	output logic ERROR_PROTECT,
	output logic PAGE_FULL,
	output logic [15:0] PAGE_ADDR,
	output logic [7:0] PAGE_WR_DATA,
	output logic [`PAGE_CNT_W-1:0] PAGE_WR_IDX,
	output logic PAGE_WR_EN,
	output logic VERIFY_ACTIVE,
	output logic [15:0] VERIFY_ADDR,
	output logic [1:0] PWR_STATE,
	output logic PWR_READY
);
	////////////////////////////////////////////////////////////////
	// mode, block select, error protection
	mode_s mode_ff, nxt_mode;
	logic [7:0] blk_ff, nxt_blk;
	logic err_ff, nxt_err;
	logic prog_ff, nxt_prog;
	logic erase_ff, nxt_erase;

	always_comb begin
		nxt_mode = MODE_SET;
		nxt_blk = ERASE_BLOCK_SELECT;
		nxt_err = POR ? ERROR_DETECT : (err_ff | ERROR_DETECT);
		nxt_prog = PROG_PULSE & MODE_SET.prog & ~nxt_err;
		nxt_erase = ERASE_PULSE & MODE_SET.erase & ~nxt_err;
	end

	always_ff @(posedge CLK) begin
		err_ff <= nxt_err;
		if (RST || POR) begin
			mode_ff <= `MODE_RST;
			blk_ff <= 8'h00;
			prog_ff <= 1'b0;
			erase_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			blk_ff <= nxt_blk;
			prog_ff <= nxt_prog;
			erase_ff <= nxt_erase;
		end
	end

	////////////////////////////////////////////////////////////////
	// page latch and verify address
	logic [15:0] pa_ff, nxt_pa;
	logic [`PAGE_CNT_W-1:0] idx_ff, nxt_idx;
	logic full_ff, nxt_full;
	logic [7:0] wd_ff, nxt_wd;
	logic [`PAGE_CNT_W-1:0] wi_ff, nxt_wi;
	logic we_ff, nxt_we;
	logic [15:0] va_ff, nxt_va;
	logic vact_ff, nxt_vact;
	logic verify_mode;

	assign verify_mode = MODE_SET.prog_verify | MODE_SET.erase_verify;

	always_comb begin
		nxt_pa = pa_ff;
		nxt_idx = idx_ff;
		nxt_full = full_ff;
		nxt_wd = wd_ff;
		nxt_wi = wi_ff;
		nxt_we = 1'b0;
		nxt_va = va_ff;
		nxt_vact = vact_ff & verify_mode;
		if (CPU.we && MODE_SET.prog && !PROG_PULSE && !full_ff) begin
			if (idx_ff == '0) begin
				nxt_pa = CPU.addr & ~16'(`PAGE_ALIGN_MASK);
			end
			nxt_wd = CPU.wdata;
			nxt_wi = idx_ff;
			nxt_we = 1'b1;
			nxt_idx = idx_ff + 1'b1;
			nxt_full = (idx_ff == `PAGE_CNT_W'(`PAGE_BYTES - 8'd1));
		end
		if (prog_ff && !PROG_PULSE) begin
			nxt_full = 1'b0;
			nxt_idx = '0;
		end
		if (CPU.we && verify_mode && CPU.wdata == `ERASED_BYTE
			&& (CPU.addr & `VERIFY_ALIGN_MASK) == 16'h0000) begin
			nxt_va = CPU.addr;
			nxt_vact = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST || POR) begin
			pa_ff <= 16'h0000;
			idx_ff <= '0;
			full_ff <= 1'b0;
			wd_ff <= 8'h00;
			wi_ff <= '0;
			we_ff <= 1'b0;
			va_ff <= 16'h0000;
			vact_ff <= 1'b0;
		end else begin
			pa_ff <= nxt_pa;
			idx_ff <= nxt_idx;
			full_ff <= nxt_full;
			wd_ff <= nxt_wd;
			wi_ff <= nxt_wi;
			we_ff <= nxt_we;
			va_ff <= nxt_va;
			vact_ff <= nxt_vact;
		end
	end

	////////////////////////////////////////////////////////////////
	// power states
	pwr_e pwr_st;
	logic pwr_rdy;
	logic [1:0] pst_ff;
	logic prdy_ff;

	flash_pwr_ctrl u_pwr (
		.clk(CLK),
		.rst(RST || POR),
		.subactive(SUBACTIVE),
		.standby_req(STANDBY_REQ),
		.flash_powerdown_enable(FLASH_POWERDOWN_ENABLE),
		.standby_wait_select(STANDBY_WAIT_SELECT),
		.state(pwr_st),
		.ready(pwr_rdy)
	);

	always_ff @(posedge CLK) begin
		if (RST || POR) begin
			pst_ff <= 2'h0;
			prdy_ff <= 1'b1;
		end else begin
			pst_ff <= pwr_st;
			prdy_ff <= pwr_rdy;
		end
	end

	assign MODE = mode_ff;
	assign BLOCK_SEL = blk_ff;
	assign PROGRAMMING = prog_ff;
	assign ERASING = erase_ff;
	assign ERROR_PROTECT = err_ff;
	assign PAGE_FULL = full_ff;
	assign PAGE_ADDR = pa_ff;
	assign PAGE_WR_DATA = wd_ff;
	assign PAGE_WR_IDX = wi_ff;
	assign PAGE_WR_EN = we_ff;
	assign VERIFY_ACTIVE = vact_ff;
	assign VERIFY_ADDR = va_ff;
	assign PWR_STATE = pst_ff;
	assign PWR_READY = prdy_ff;

	////////////////////////////////////////////////////////////////
	// checks
	a_prog_follows_pulse: assert property (@(posedge CLK) disable iff (RST || POR)
		!$past(RST || POR)
		|-> PROGRAMMING == $past(PROG_PULSE & MODE_SET.prog & ~(err_ff | ERROR_DETECT)))
		else $error("program pulse mismatch");
	a_err_blocks_prog: assert property (@(posedge CLK) disable iff (RST || POR)
		ERROR_PROTECT |=> !PROGRAMMING && !ERASING)
		else $error("pulse while protected");
	a_err_sticky: assert property (@(posedge CLK) disable iff (POR)
		ERROR_PROTECT |=> ERROR_PROTECT)
		else $error("protection lost");
	a_err_abort: assert property (@(posedge CLK) disable iff (RST || POR)
		ERROR_DETECT |=> !PROGRAMMING && !ERASING && ERROR_PROTECT)
		else $error("abort missing");
	a_mode_kept: assert property (@(posedge CLK) disable iff (RST || POR)
		ERROR_DETECT |=> MODE == $past(MODE_SET) && BLOCK_SEL == $past(ERASE_BLOCK_SELECT))
		else $error("mode lost on error");
	a_mode_track: assert property (@(posedge CLK) disable iff (RST || POR)
		1'b1 |=> MODE == $past(MODE_SET))
		else $error("mode not selected");
	a_page_align: assert property (@(posedge CLK) disable iff (RST || POR)
		PAGE_ADDR[6:0] == 7'h00)
		else $error("page misaligned");
	a_verify_align: assert property (@(posedge CLK) disable iff (RST || POR)
		$rose(VERIFY_ACTIVE) |-> VERIFY_ADDR[1:0] == 2'b00)
		else $error("verify address misaligned");
	a_verify_allowed: assert property (@(posedge CLK) disable iff (RST || POR)
		CPU.we && MODE_SET.prog_verify && CPU.wdata == 8'hff && CPU.addr[1:0] == 2'b00
		|=> VERIFY_ACTIVE)
		else $error("verify blocked");
	a_pdown_entry: assert property (@(posedge CLK) disable iff (RST || POR)
		pwr_st == PWR_NORMAL && !STANDBY_REQ && SUBACTIVE && FLASH_POWERDOWN_ENABLE
		|=> pwr_st == PWR_DOWN)
		else $error("power-down not entered");
	a_wake_wait: assert property (@(posedge CLK) disable iff (RST || POR)
		$rose(pwr_st == PWR_WAKE) |-> (pwr_st == PWR_WAKE)[*8])
		else $error("wake too short");
endmodule // flash_program_erase_control

// ### tb.sv
`timescale 1ns/1ps
module tb;
	import flash_ctrl_pkg::*;
	logic clk = 0, rst = 1, por = 1, pp = 0, ep = 0, err = 0, sub = 0, sreq = 0, pde = 0;
	cpu_acc_s cpu = '0;
	mode_s ms = '0;
	mode_s mode;
	logic [7:0] ebs = 8'h00, bsel, pwd, d;
	logic [2:0] sel = 3'h0;
	logic prg, ers, prot, full, pwe, va, prdy;
	logic [15:0] pa, vaddr, base;
	logic [6:0] pidx, exp_idx = 7'h00;
	logic [1:0] pst;
	int bad_count = 0, compares = 0, seed = 4600, cyc = 0, n;
	logic [7:0] q[$];
	flash_program_erase_control u_dut (.CLK(clk), .RST(rst), .POR(por), .CPU(cpu),
		.MODE_SET(ms), .PROG_PULSE(pp), .ERASE_PULSE(ep), .ERASE_BLOCK_SELECT(ebs),
		.ERROR_DETECT(err), .SUBACTIVE(sub), .STANDBY_REQ(sreq),
		.FLASH_POWERDOWN_ENABLE(pde), .STANDBY_WAIT_SELECT(sel), .MODE(mode),
		.BLOCK_SEL(bsel), .PROGRAMMING(prg), .ERASING(ers), .ERROR_PROTECT(prot),
		.PAGE_FULL(full), .PAGE_ADDR(pa), .PAGE_WR_DATA(pwd), .PAGE_WR_IDX(pidx),
		.PAGE_WR_EN(pwe), .VERIFY_ACTIVE(va), .VERIFY_ADDR(vaddr), .PWR_STATE(pst),
		.PWR_READY(prdy));
	initial forever #4 clk = ~clk;
	////////////////////////////////////////////////////////////////
	function automatic int min_wait();
		return 20000 / 8;
	endfunction
	function automatic logic [15:0] page_base(input logic [15:0] a);
		return {a[15:7], 7'h00};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic wake();
		n = 0;
		while (pst !== 2'h0 && n < 12000) begin
			tick(1);
			n++;
		end
		chk("wake_long", 16'h1, 16'(n >= min_wait()));
		chk("pwr_normal", 16'h0, 16'(pst));
		chk("wake_ready", 16'h1, 16'(prdy));
	endtask
	task automatic complete_run();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	always @(negedge clk) if (pwe === 1'b1) begin
		chk("wr_idx", 16'(exp_idx), 16'(pidx));
		chk("wr_data", (q.size() > 0) ? 16'(q.pop_front()) : 16'hxxxx, 16'(pwd));
		exp_idx = exp_idx + 7'h1;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		tick(16);
		rst = 0;
		por = 0;
		tick(1);
		chk("pwr_ready", 16'h1, 16'(prdy));
		chk("protect_rst", 16'h0, 16'(prot));
		for (int m = 0; m < 4; m++) begin
			ms = mode_s'(4'h8 >> m);
			tick(2);
			chk("mode", 16'(ms), 16'(mode));
		end
		ms = '0;
		ms.prog = 1'b1;
		for (int p = 0; p < 2; p++) begin
			base = {8'($random(seed)), p ? 8'h00 : 8'h80};
			exp_idx = 7'h00;
			cpu.we = 1'b1;
			for (int i = 0; i < 128; i++) begin
				d = (p == 1 && i > 119) ? 8'hff : 8'($random(seed));
				q.push_back(d);
				cpu.addr = base + 16'(i);
				cpu.wdata = d;
				tick(1);
			end
			cpu.we = 1'b0;
			tick(1);
			cpu.we = 1'b1;
			tick(1);
			cpu.we = 1'b0;
			tick(2);
			chk("page_full", 16'h1, 16'(full));
			chk("page_addr", page_base(base), pa);
			chk("bytes_left", 16'h0, 16'(q.size()));
			pp = 1'b1;
			tick(2);
			chk("prog_on", 16'h1, 16'(prg));
			tick(20);
			chk("prog_hold", 16'h1, 16'(prg));
			pp = 1'b0;
			tick(2);
			chk("prog_off", 16'h0, 16'(prg));
			chk("full_off", 16'h0, 16'(full));
		end
		ms = '0;
		ms.prog_verify = 1'b1;
		tick(2);
		base = {8'($random(seed)), 8'($random(seed)) & 8'hfc};
		cpu.we = 1'b1;
		cpu.addr = base;
		cpu.wdata = 8'hff;
		tick(1);
		cpu.we = 1'b0;
		tick(2);
		chk("verify_on", 16'h1, 16'(va));
		chk("verify_addr", base, vaddr);
		ms = '0;
		ms.erase = 1'b1;
		ebs = 8'($random(seed));
		ep = 1'b1;
		tick(3);
		chk("erase_on", 16'h1, 16'(ers));
		err = 1'b1;
		tick(1);
		err = 1'b0;
		tick(2);
		chk("erase_abort", 16'h0, 16'(ers));
		chk("protect_set", 16'h1, 16'(prot));
		chk("mode_kept", 16'(ms), 16'(mode));
		chk("block_kept", 16'(ebs), 16'(bsel));
		ep = 1'b0;
		tick(2);
		ep = 1'b1;
		tick(3);
		chk("erase_blocked", 16'h0, 16'(ers));
		ep = 1'b0;
		ms = '0;
		ms.prog = 1'b1;
		pp = 1'b1;
		tick(3);
		chk("prog_blocked", 16'h0, 16'(prg));
		pp = 1'b0;
		ms = '0;
		ms.erase_verify = 1'b1;
		tick(2);
		chk("verify_mode", 16'(ms), 16'(mode));
		base = base ^ 16'h0040;
		cpu.we = 1'b1;
		cpu.addr = base;
		cpu.wdata = 8'hff;
		tick(1);
		cpu.we = 1'b0;
		tick(2);
		chk("verify_prot", 16'h1, 16'(va));
		chk("verify_prot_addr", base, vaddr);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(1);
		chk("protect_keep", 16'h1, 16'(prot));
		por = 1'b1;
		tick(2);
		por = 1'b0;
		tick(1);
		chk("protect_clr", 16'h0, 16'(prot));
		sub = 1'b1;
		pde = 1'b1;
		tick(3);
		chk("pwr_down", 16'h1, 16'(pst));
		chk("down_ready", 16'h0, 16'(prdy));
		sub = 1'b0;
		pde = 1'b0;
		wake();
		sel = 3'h1;
		sreq = 1'b1;
		tick(3);
		chk("pwr_standby", 16'h2, 16'(pst));
		chk("standby_ready", 16'h0, 16'(prdy));
		sreq = 1'b0;
		wake();
		complete_run();
	end
endmodule // tb
